// >>> core/sync_update_segment_control.sv
// Summary of operation
// R01: Control bit 3 clear enables runt suppression, set disables it.
// R02: Control bit 2 set powers down the output alignment circuitry.
// R03: Control bit 1 set powers down the distribution reference.
// R04: Soft alignment bit high holds selected outputs in static state.
// R05: Soft alignment bit falling from one launches an alignment event.
// R06: Soft alignment bit behaves as the inverse of the alignment pin.
// R07: Host writes one to update bit; buffers copy into active copies.
// R08: Copy happens on the clock edge following the update write.
// R09: Update bit clears itself after the copy is done.
// R10: Segment list holds start addresses and byte counts for memory.
// R11: Segment list may hold apply-settings and end-of-list opcodes.
// R12: Reset list saves and restores all registers, then applies.
// R13: Buffered writes act only after update or apply-settings copy.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "sync_seg_params.svh"

module sync_update_segment_control
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [ADDR_W-1:0]     i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic [31:0]                o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic                  i_sync_pin_n,
  input  wire logic                  i_apply_settings,
  input  wire sync_seg_pkg::seg_idx_t i_seg_ctl_idx,
  output sync_seg_pkg::byte_t        o_seg_ctl_data,
  output sync_seg_pkg::entry_kind_t  o_seg_ctl_kind,
  output logic                       o_runt_suppress_en,
  output logic                       o_sync_power_down,
  output logic                       o_dist_ref_power_down,
  output logic                       o_sync_force_static,
  output logic                       o_sync_event,
  output logic                       o_update_all
);

  logic [3:0]              sys_buf_ff;
  logic [3:0]              sys_act_ff;
  logic                    update_ff;
  logic                    copy_ff;
  logic [31:0]             prdata_ff;
  logic                    pslverr_ff;
  logic                    access;
  logic                    wr_access;
  logic                    rd_access;
  logic                    aligned;
  logic [ADDR_W-3:0]       reg_idx;
  logic                    hit_sys;
  logic                    hit_upd;
  logic                    hit_stat;
  logic                    hit_seg;
  logic                    mapped;
  logic                    copy_now;
  logic [3:0]              nxt_sys_act;
  logic [31:0]             nxt_prdata;
  sync_seg_pkg::seg_idx_t  seg_idx;
  sync_seg_pkg::byte_t     seg_rd_data;
  logic                    pin_level;
  logic                    update_req;
  logic                    sys_wr_en;
  logic                    seg_wr_en;
  logic [5:0]              status_word;
  logic                    runt_en_ff;
  logic                    sync_pd_ff;
  logic                    ref_pd_ff;
  sync_seg_pkg::byte_t     seg_ctl_raw;
  sync_seg_pkg::byte_t     seg_ctl_data_ff;
  sync_seg_pkg::entry_kind_t seg_ctl_kind_ff;

  // Reset image of the control register, for per-bit reset values
  localparam logic [3:0] SYS_RST = `SYS_SYNC_RESET;

  // Index of an aligned word address
  function automatic logic [ADDR_W-3:0] word_index(
    input logic [ADDR_W-1:0] addr);
    word_index = addr[ADDR_W-1:2];
  endfunction : word_index

  // Aligned hit on one register index
  function automatic logic hits_index(
    input logic [ADDR_W-1:0] addr,
    input logic [13:0]       idx);
    hits_index = (addr[1:0] == 2'h0) && (14'(word_index(addr)) == idx);
  endfunction : hits_index

  // Decode of an opcode or data byte of the list
  function automatic sync_seg_pkg::entry_kind_t classify(
    input sync_seg_pkg::byte_t data);
    if (data == `SEG_OP_END)
      classify = sync_seg_pkg::ENTRY_END;
    else if (data == `SEG_OP_APPLY)
      classify = sync_seg_pkg::ENTRY_APPLY;
    else
      classify = sync_seg_pkg::ENTRY_SEGMENT;
  endfunction : classify

  // APB phase qualifiers
  always_comb
  begin
    access    = i_psel & i_penable;
    wr_access = access & i_pwrite;
    rd_access = access & ~i_pwrite;
  end

  // Register address decode
  always_comb
  begin
    aligned   = (i_paddr[1:0] == 2'h0);
    reg_idx   = word_index(i_paddr);
    hit_sys   = hits_index(i_paddr, `IDX_SYS_SYNC_CTRL);
    hit_upd   = hits_index(i_paddr, `IDX_UPDATE_STROBE);
    hit_stat  = hits_index(i_paddr, `IDX_CTRL_STATUS);
    hit_seg   = aligned && (14'(reg_idx) >= `IDX_SEG_FIRST)
                        && (14'(reg_idx) <= `IDX_SEG_LAST);
    mapped    = hit_sys | hit_upd | hit_stat | hit_seg;
    seg_idx   = 5'(14'(reg_idx) - `IDX_SEG_FIRST);
  end

  assign o_pready = 1'b1;

  // Write enables of the writable targets
  assign update_req = wr_access & hit_upd & i_pwdata[`BIT_UPDATE];
  assign sys_wr_en  = wr_access & hit_sys;
  assign seg_wr_en  = wr_access & hit_seg;

  // Buffer copy of the control register
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sys_buf_ff <= `SYS_SYNC_RESET;
    else if (sys_wr_en)
      sys_buf_ff <= i_pwdata[3:0];
  end

  // R07: host write requests copy
  // R09: bit clears after copy
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      update_ff <= 1'b0;
    // Set wins over the self-clear
    else if (update_req)
      update_ff <= 1'b1;
    else if (update_ff)
      update_ff <= 1'b0;
  end

  // R13: apply-settings also copies
  assign copy_now = update_ff | i_apply_settings;

  // R08: copy on following edge
  always_comb
  begin
    nxt_sys_act = copy_now ? sys_buf_ff : sys_act_ff;
  end

  // R13: active only via copy
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sys_act_ff <= `SYS_SYNC_RESET;
    else
      sys_act_ff <= nxt_sys_act;
  end

  // Strobe to other buffered blocks, same edge as local copy
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      copy_ff <= 1'b0;
    else
      copy_ff <= copy_now;
  end

  // Status: synced pin, pending update, active copy
  always_comb
  begin
    status_word = {pin_level, update_ff, sys_act_ff};
  end

  // Read data mux
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    if (hit_sys)
      nxt_prdata[3:0] = sys_buf_ff;
    else if (hit_upd)
      nxt_prdata[`BIT_UPDATE] = update_ff;
    else if (hit_stat)
      nxt_prdata[5:0] = status_word;
    else if (hit_seg)
      nxt_prdata[7:0] = seg_rd_data;
  end

  // Registered answer, latched in setup, shown in access
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prdata_ff <= 32'h0000_0000;
    else if (i_psel && !i_penable)
      prdata_ff <= i_pwrite ? 32'h0000_0000 : nxt_prdata;
  end

  // Refused: unmapped, misaligned, or a write to status
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pslverr_ff <= 1'b0;
    else if (i_psel && !i_penable)
      pslverr_ff <= ~mapped | (i_pwrite & hit_stat);
  end

  assign o_prdata  = (rd_access) ? prdata_ff : 32'h0000_0000;
  assign o_pslverr = access & pslverr_ff;

  // R10: segment storage
  // R12: reset defaults inside
  seg_list_mem #(
    .DEPTH (`SEG_DEPTH)
  ) u_seg_list (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_wr_en    (seg_wr_en),
    .i_wr_idx   (seg_idx),
    .i_wr_data  (i_pwdata[7:0]),
    .i_rd_idx   (seg_idx),
    .o_rd_data  (seg_rd_data),
    .i_ctl_idx  (i_seg_ctl_idx),
    .o_ctl_data (seg_ctl_raw)
  );

  // Controller view from flops, one cycle behind its index
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      seg_ctl_data_ff <= `SEG_FILL;
      seg_ctl_kind_ff <= sync_seg_pkg::ENTRY_SEGMENT;
    end
    else
    begin
      seg_ctl_data_ff <= seg_ctl_raw;
      // R11: opcode decode for controller
      seg_ctl_kind_ff <= classify(seg_ctl_raw);
    end
  end

  assign o_seg_ctl_data = seg_ctl_data_ff;
  assign o_seg_ctl_kind = seg_ctl_kind_ff;

  // R04: static hold and events
  // R05: falling soft bit event
  sync_edge_detect u_sync (
    .i_core_clk     (i_core_clk),
    .i_reset_n      (i_reset_n),
    .i_sync_pin_n   (i_sync_pin_n),
    .i_soft_sync    (sys_act_ff[`BIT_SOFT_SYNC]),
    .i_power_down   (sys_act_ff[`BIT_SYNC_PWRDN]),
    .o_pin_level    (pin_level),
    .o_force_static (o_sync_force_static),
    .o_sync_event   (o_sync_event)
  );

  // R01: clear enables suppression
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      runt_en_ff <= ~SYS_RST[`BIT_RUNT_DISABLE];
    else
      runt_en_ff <= ~nxt_sys_act[`BIT_RUNT_DISABLE];
  end

  // R02: alignment power down
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sync_pd_ff <= SYS_RST[`BIT_SYNC_PWRDN];
    else
      sync_pd_ff <= nxt_sys_act[`BIT_SYNC_PWRDN];
  end

  // R03: reference power down
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ref_pd_ff <= SYS_RST[`BIT_DIST_REF_PWRDN];
    else
      ref_pd_ff <= nxt_sys_act[`BIT_DIST_REF_PWRDN];
  end

  assign o_runt_suppress_en    = runt_en_ff;
  assign o_sync_power_down     = sync_pd_ff;
  assign o_dist_ref_power_down = ref_pd_ff;
  assign o_update_all          = copy_ff;

endmodule : sync_update_segment_control

// >>> include/sync_seg_params.svh
`ifndef SYNC_SEG_PARAMS_SVH
`define SYNC_SEG_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_SYS_SYNC_CTRL    14'h0230
`define IDX_UPDATE_STROBE    14'h0232
`define IDX_CTRL_STATUS      14'h0234
`define IDX_SEG_FIRST        14'h0a00
`define IDX_SEG_LAST         14'h0a16

// Fields of the system sync control register
`define BIT_RUNT_DISABLE     3
`define BIT_SYNC_PWRDN       2
`define BIT_DIST_REF_PWRDN   1
`define BIT_SOFT_SYNC        0
`define SYS_SYNC_RESET       4'h0

// Update strobe field
`define BIT_UPDATE           0

// Segment list layout
`define SEG_DEPTH            23
`define SEG_OP_FLAG_BIT      7
`define SEG_OP_APPLY         8'h80
`define SEG_OP_END           8'hff
`define SEG_FILL             8'h00

`endif

// >>> include/sync_seg_pkg.sv
package sync_seg_pkg;

  typedef logic [7:0] byte_t;

  typedef logic [4:0] seg_idx_t;

  typedef enum logic [2:0] {
    ENTRY_SEGMENT = 3'h1,
    ENTRY_APPLY   = 3'h2,
    ENTRY_END     = 3'h4
  } entry_kind_t;

endpackage : sync_seg_pkg

// >>> core/sync_edge_detect.sv
`timescale 1ns/1ns
`include "sync_seg_params.svh"

module sync_edge_detect
(
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_sync_pin_n,
  input  wire logic i_soft_sync,
  input  wire logic i_power_down,
  output logic      o_pin_level,
  output logic      o_force_static,
  output logic      o_sync_event
);

  logic meta_ff;
  logic pin_ff;
  logic pin_prev_ff;
  logic soft_prev_ff;
  logic force_ff;
  logic event_ff;
  logic nxt_force;
  logic nxt_event;

  // Two-stage synchroniser, pin idles high
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_ff <= 1'b1;
      pin_ff  <= 1'b1;
    end
    else
    begin
      meta_ff <= i_sync_pin_n;
      pin_ff  <= meta_ff;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_prev_ff  <= 1'b1;
      soft_prev_ff <= 1'b0;
    end
    else
    begin
      pin_prev_ff  <= pin_ff;
      soft_prev_ff <= i_soft_sync;
    end
  end

  always_comb
  begin
    // R06: bit inverse of pin
    // R04: hold static state
    nxt_force = ~i_power_down & (i_soft_sync | ~pin_ff);
    // R05: falling bit launches
    nxt_event = ~i_power_down & ((soft_prev_ff & ~i_soft_sync)
                               | (~pin_prev_ff & pin_ff));
  end

  // R02: powered down, no alignment
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      force_ff <= 1'b0;
      event_ff <= 1'b0;
    end
    else
    begin
      force_ff <= nxt_force;
      event_ff <= nxt_event;
    end
  end

  assign o_pin_level    = pin_ff;
  assign o_force_static = force_ff;
  assign o_sync_event   = event_ff;

endmodule : sync_edge_detect

// >>> core/seg_list_mem.sv
`timescale 1ns/1ns
`include "sync_seg_params.svh"

module seg_list_mem
#(
  parameter int DEPTH = `SEG_DEPTH
)
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_wr_en,
  input  wire sync_seg_pkg::seg_idx_t i_wr_idx,
  input  wire sync_seg_pkg::byte_t  i_wr_data,
  input  wire sync_seg_pkg::seg_idx_t i_rd_idx,
  output sync_seg_pkg::byte_t       o_rd_data,
  input  wire sync_seg_pkg::seg_idx_t i_ctl_idx,
  output sync_seg_pkg::byte_t       o_ctl_data
);

  sync_seg_pkg::byte_t list_ff [DEPTH];

  // Default list: five segments of {count-1, addr hi, addr lo}
  // spanning addresses 0x0000 to 0x0233, then apply-settings, then end marker
  function automatic sync_seg_pkg::byte_t default_entry(input int idx);
    case (idx)
      0:       default_entry = 8'h7f;
      1:       default_entry = 8'h00;
      2:       default_entry = 8'h00;
      3:       default_entry = 8'h7f;
      4:       default_entry = 8'h00;
      5:       default_entry = 8'h80;
      6:       default_entry = 8'h7f;
      7:       default_entry = 8'h01;
      8:       default_entry = 8'h00;
      9:       default_entry = 8'h7f;
      10:      default_entry = 8'h01;
      11:      default_entry = 8'h80;
      12:      default_entry = 8'h33;
      13:      default_entry = 8'h02;
      14:      default_entry = 8'h00;
      15:      default_entry = `SEG_OP_APPLY;
      16:      default_entry = `SEG_OP_END;
      default: default_entry = `SEG_FILL;
    endcase
  endfunction : default_entry

  // R12: reset list saves all
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        list_ff[i] <= default_entry(i);
    end
    else if (i_wr_en && (int'(i_wr_idx) < DEPTH))
    begin
      // R10: host edits segments
      list_ff[i_wr_idx] <= i_wr_data;
    end
  end

  assign o_rd_data  = (int'(i_rd_idx) < DEPTH) ? list_ff[i_rd_idx] : 8'h00;
  assign o_ctl_data = (int'(i_ctl_idx) < DEPTH) ? list_ff[i_ctl_idx]
                                                : `SEG_OP_END;

endmodule : seg_list_mem

// >>> tb/sync_ctl_monitor.sv
`timescale 1ns/1ns
module sync_ctl_monitor
#(
  parameter int ADDR_W = 16
)
(
  input wire logic              i_core_clk,
  input wire logic              i_reset_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              i_sync_pin_n,
  input wire logic              i_apply_settings,
  input wire logic              o_runt_suppress_en,
  input wire logic              o_sync_power_down,
  input wire logic              o_dist_ref_power_down,
  input wire logic              o_sync_force_static,
  input wire logic              o_sync_event,
  input wire logic              o_update_all
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire upd_wr = i_psel && i_penable && i_pwrite && i_pwdata[0]
                && i_paddr == 16'h08c8;
  a_copy_gates_runt: assert property ($changed(o_runt_suppress_en)
    |-> o_update_all || $past(i_apply_settings))
    else $error("runt control moved without a copy");
  a_copy_gates_pd: assert property ($changed(o_sync_power_down)
    |-> o_update_all || $past(i_apply_settings))
    else $error("sync power-down moved without a copy");
  a_copy_gates_ref: assert property ($changed(o_dist_ref_power_down)
    |-> o_update_all || $past(i_apply_settings))
    else $error("reference power-down moved without a copy");
  a_update_next_edge: assert property (upd_wr
    |-> ##1 !o_update_all ##1 o_update_all)
    else $error("update copy not on the following edge");
  a_update_self_clear: assert property (o_update_all |=> !o_update_all)
    else $error("update strobe did not clear");
  a_pd_blocks_sync: assert property (o_sync_power_down
    && $past(o_sync_power_down) |-> !o_sync_event && !o_sync_force_static)
    else $error("alignment active while powered down");
  a_pin_rise_event: assert property ($rose(i_sync_pin_n)
    && !o_sync_power_down |-> ##[1:4] o_sync_event)
    else $error("pin release gave no alignment event");
  a_pin_low_static: assert property ((!i_sync_pin_n
    && !o_sync_power_down)[*5] |-> o_sync_force_static)
    else $error("pin low did not force static state");
  a_event_one_cycle: assert property (o_sync_event |=> !o_sync_event)
    else $error("alignment event longer than a cycle");
  c_update: cover property (o_update_all);
  c_event: cover property (o_sync_event);
  c_apply: cover property (i_apply_settings);
endmodule : sync_ctl_monitor

bind sync_update_segment_control sync_ctl_monitor #(.ADDR_W(ADDR_W)) u_mon
(
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_sync_pin_n(i_sync_pin_n),
  .i_apply_settings(i_apply_settings),
  .o_runt_suppress_en(o_runt_suppress_en),
  .o_sync_power_down(o_sync_power_down),
  .o_dist_ref_power_down(o_dist_ref_power_down),
  .o_sync_force_static(o_sync_force_static),
  .o_sync_event(o_sync_event), .o_update_all(o_update_all)
);

// >>> tb/apb_host_model.sv
`timescale 1ns/1ns
module apb_host_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [15:0]      o_paddr,
  output logic [31:0]      o_pwdata
);
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 16'h0000;
    o_pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err, output logic tmo);
    int n;
    @(posedge i_core_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    tmo = 1'b1;
    for (n = 0; n < 16 && tmo; n++)
    begin
      @(posedge i_core_clk);
      tmo = (i_pready !== 1'b1);
    end
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released lines do not keep last value
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
endmodule : apb_host_model

// >>> tb/sync_update_segment_control_tb_top.sv
`timescale 1ns/1ns
module sync_update_segment_control_tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pin_n, apply;
  logic        pready, pslverr, runt, spd, rpd, fst, ev, upd, err, tmo;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sync_seg_pkg::seg_idx_t    cidx;
  sync_seg_pkg::byte_t       cdat;
  sync_seg_pkg::entry_kind_t ckind;
  int          n_mismatch, samples_checked, i;
  localparam logic [15:0] A_CTRL = 16'h08c0;
  localparam logic [15:0] A_UPD = 16'h08c8;
  localparam logic [15:0] A_STAT = 16'h08d0;
  localparam logic [15:0] A_LAST = 16'h2858;
  localparam logic [4:0] IDX [3] = '{5'd0, 5'd15, 5'd16};
  localparam logic [7:0] DAT [3] = '{8'h7f, 8'h80, 8'hff};
  localparam logic [7:0] KND [3] = '{8'h01, 8'h02, 8'h04};

  sync_update_segment_control #(.ADDR_W(16)) DUT
  (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sync_pin_n(pin_n), .i_apply_settings(apply),
    .i_seg_ctl_idx(cidx), .o_seg_ctl_data(cdat), .o_seg_ctl_kind(ckind),
    .o_runt_suppress_en(runt), .o_sync_power_down(spd),
    .o_dist_ref_power_down(rpd), .o_sync_force_static(fst),
    .o_sync_event(ev), .o_update_all(upd)
  );

  apb_host_model host
  (
    .i_core_clk(clk), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata)
  );

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic tally_and_finish;
    $display("Mismatches %0d of %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic hang;
    n_mismatch++;
    $display("Error at %0t: wait ran out %h %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask : hang

  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    host.xfer(w, a, d, rd, err, tmo);
    if (tmo)
      hang();
  endtask : bus

  task automatic wait_ev(input logic want_event);
    int n;
    for (n = 0; n < 20; n++)
    begin
      @(negedge clk);
      if ((want_event ? ev : fst) === 1'b1)
        return;
    end
    hang();
  endtask : wait_ev

  task automatic t_update;
    @(negedge clk);
    chk_out(8'({runt, spd, rpd, fst}), 8'h08);
    bus(1'b1, A_CTRL, 32'he);
    @(negedge clk);
    chk_out(8'({runt, spd, rpd}), 8'h04);
    bus(1'b0, A_CTRL, 32'h0);
    chk_rd(rd, 32'he);
    bus(1'b0, A_STAT, 32'h0);
    chk_rd(rd, 32'h20);
    bus(1'b1, A_UPD, 32'h1);
    @(negedge clk);
    chk_out(8'({upd, runt, spd, rpd}), 8'h04);
    @(negedge clk);
    chk_out(8'({upd, runt, spd, rpd}), 8'h0b);
    bus(1'b0, A_UPD, 32'h0);
    chk_rd(rd, 32'h0);
    pin_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk_out(8'(fst), 8'h00);
    @(posedge clk) pin_n <= 1'b1;
    bus(1'b1, A_CTRL, 32'h0);
    apply <= 1'b1;
    @(posedge clk) apply <= 1'b0;
    @(negedge clk);
    chk_out(8'({runt, spd, rpd}), 8'h04);
  endtask : t_update

  task automatic t_sync;
    bus(1'b1, A_CTRL, 32'h1);
    bus(1'b1, A_UPD, 32'h1);
    wait_ev(1'b0);
    bus(1'b1, A_CTRL, 32'h0);
    bus(1'b1, A_UPD, 32'h1);
    wait_ev(1'b1);
    chk_out(8'(fst), 8'h00);
    @(posedge clk) pin_n <= 1'b0;
    wait_ev(1'b0);
    @(posedge clk) pin_n <= 1'b1;
    wait_ev(1'b1);
  endtask : t_sync

  task automatic t_seg;
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk) cidx <= IDX[i];
      repeat (2) @(negedge clk);
      chk_out(cdat, DAT[i]);
      chk_out(8'(ckind), KND[i]);
    end
    bus(1'b1, A_LAST, 32'h5a);
    cidx <= 5'd22;
    bus(1'b0, A_LAST, 32'h0);
    chk_rd(rd, 32'h5a);
    chk_out(cdat, 8'h5a);
    bus(1'b0, 16'h0004, 32'h0);
    chk_out(8'(err), 8'h01);
    bus(1'b1, A_CTRL + 16'h0002, 32'hf);
    chk_out(8'(err), 8'h01);
    bus(1'b1, A_STAT, 32'h1);
    chk_out(8'(err), 8'h01);
  endtask : t_seg

  task automatic t_reset;
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk_out(8'({runt, spd, rpd, fst}), 8'h08);
    chk_out(cdat, 8'h00);
    bus(1'b0, A_LAST, 32'h0);
    chk_rd(rd, 32'h0);
  endtask : t_reset

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    apply = 1'b0;
    cidx = 5'd0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_update();
    t_sync();
    t_seg();
    t_reset();
    tally_and_finish();
  end
endmodule : sync_update_segment_control_tb_top
